// ==== rtl/vcd_pkg.sv ====
// constants shared by the two-channel video capture descriptor dma engine
package vcd_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NCH = 2;
	localparam int FIFO_DEPTH = 128;
	localparam int FIFO_AW = 7;
	localparam int CACHE_N = 4;
	// ------------------------------------------------------------
	// register map (byte addresses, 8-bit address port)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [1:0] CH_SEL_A = 2'h1; // channel a at 0x40..0x7f
	localparam logic [5:0] OFF_ROWLEN = 6'h00;
	localparam logic [5:0] OFF_ROWCNT = 6'h04;
	localparam logic [5:0] OFF_DWOFF = 6'h08;
	localparam logic [5:0] OFF_FETCH = 6'h0c;
	localparam logic [5:0] OFF_FIRST = 6'h10;
	localparam logic [5:0] OFF_THRESH = 6'h14;
	localparam logic [5:0] OFF_FIFOPTR = 6'h18;
	localparam logic [5:0] OFF_CVALID = 6'h1c;
	localparam logic [3:0] OFF_CACHE_HI = 4'h2; // entries at 0x20,0x24,0x28,0x2c
	// ------------------------------------------------------------
	// control bits
	// ------------------------------------------------------------
	localparam int CTL_LITTLE = 0;
	localparam int CTL_EN = 1; // + channel
	localparam int CTL_ILV = 3; // + channel
	localparam int CTL_IE = 5; // + 3*channel + event
	// ------------------------------------------------------------
	// status bits: 3*channel + event
	// ------------------------------------------------------------
	localparam int EV_EOT = 0;
	localparam int EV_OVF = 1;
	localparam int EV_EOF = 2;
	localparam int NEV = 3;
	// ------------------------------------------------------------
	// descriptor fields
	// ------------------------------------------------------------
	localparam int D_VALID = 32;
	localparam int D_STOP = 31;
	localparam int D_JUMP = 30;
	localparam logic [31:0] FETCH_STEP = 32'h0000_0010;
	localparam logic [9:0] DW_STEP = 10'h001;
	localparam logic [31:0] ROW_STEP = 32'h0000_0008;
	localparam logic [7:0] THRESH_RST = 8'h40;
	// ------------------------------------------------------------
	// arbiter requester indices
	// ------------------------------------------------------------
	localparam logic [1:0] ARB_NONE = 2'h0;
endpackage : vcd_pkg

// ==== rtl/vcd_dma.sv ====
// two-channel video capture dma with descriptor cache and bus arbiter
// Function
// RQ1: one shared control bit picks little endian at 1, big endian at 0.
// RQ2: disabled channel holds fifo pointers at zero; software programs only while disabled.
// RQ3: interleave bit assembles two consecutive fields into one frame in memory.
// RQ4: status bits set by hardware only, cleared by software writes only.
// RQ5: end-of-field flag set after last field byte crosses the bus; dma continues.
// RQ6: fifo overflow sets flag and halts dma; software disables, reinitialises, clears.
// RQ7: stop descriptor active sets end-of-table flag and halts dma at once.
// RQ8: software uses line lengths multiple of 8, programs row length minus 8.
// RQ9: row byte counter steps by 8 per transfer, wraps to zero at row length.
// RQ10: offset gives address bits 11:3, descriptor the upper, bits 2:0 zero.
// RQ11: fetch pointer is quadword aligned and steps by sixteen per descriptor fetch.
// RQ12: software should set frame-first pointer equal to fetch pointer.
// RQ13: four 33-bit cache entries readable and writable; write marks entry valid.
// RQ14: offset rollover shifts cache up; invalid entry at zero fetches four descriptors.
// RQ15: valid jump descriptor at zero fetches new group from its pointer field.
// RQ16: software write of fetch pointer invalidates cache and starts a fetch.
// RQ17: descriptor valid 32, stop 31, jump 30; bits 31:30 zero on address.
// RQ18: software aligns tables and ends each with stop or jump descriptor.
// RQ19: each channel has a 128 by 64 fifo, readable pointers, programmable threshold.
// RQ20: fixed priority a fetch, a dma, b fetch, b dma; bus request while any.
// RQ21: active-low interrupt held while any of six enabled conditions pending.
// RQ22: end-of-field only on enabled channels and never on dropped fields.
// RQ23: dma requests at threshold and keeps transferring until the fifo empties.
// RQ24: interleave advances offset by row length plus one after each line.
// RQ25: after halt no bus requests until flag cleared and fetch pointer rewritten.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module vcd_dma (
	input wire logic clock, // 200 MHz
	input wire logic rstn, // synchronous, active low
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic [1:0] pix_valid, // per channel pixel word strobe
	input wire logic [127:0] pix_data, // channel b in upper half
	input wire logic [1:0] field_end, // last pixel of field written, pulse
	input wire logic [1:0] field_drop, // field dropped by rate control
	output logic bus_req, // system bus request
	input wire logic bus_gnt, // system bus grant
	output logic bus_valid, // beat offered
	output logic bus_write, // 1 write beat, 0 read beat
	output logic [31:0] bus_addr, // beat address
	output logic [63:0] bus_wdata, // write beat data
	input wire logic bus_ready, // beat taken
	input wire logic bus_rvalid, // read word returned
	input wire logic [31:0] bus_rdata, // read word
	output logic host_irq_n // interrupt, active low
);
	// ------------------------------------------------------------
	// shared state
	// ------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [5:0] status_q;
	logic [5:0] ev_set;
	logic [3:0] unit_req;
	logic [3:0] unit_gnt;
	logic [1:0] owner_q;
	logic own_v_q;
	logic [31:0] ch_rdata [vcd_pkg::NCH];
	logic [31:0] f_addr [vcd_pkg::NCH];
	logic f_valid [vcd_pkg::NCH];
	logic [31:0] d_addr [vcd_pkg::NCH];
	logic [63:0] d_data [vcd_pkg::NCH];
	logic d_valid [vcd_pkg::NCH];
	logic wr_ctrl;
	logic wr_status;

	function automatic logic [63:0] vcd_swap(input logic [63:0] w);
		logic [63:0] r;
		r = '0;
		for (int i = 0; i < 8; i++)
		begin
			r[8*i +: 8] = w[8*(7-i) +: 8];
		end
		return r;
	endfunction : vcd_swap

	assign wr_ctrl = reg_wr && (reg_addr == vcd_pkg::OFF_CTRL);
	assign wr_status = reg_wr && (reg_addr == vcd_pkg::OFF_STATUS);

	// control register, software owned
	always_ff @(posedge clock)
	begin
		if (!rstn)
			ctrl_q <= '0;
		else if (wr_ctrl)
			ctrl_q <= reg_wdata;
	end

	// status: hardware sets, writing 1 clears, set wins
	always_ff @(posedge clock)
	begin
		if (!rstn)
			status_q <= '0;
		else if (wr_status)
			status_q <= (status_q & ~reg_wdata[5:0]) | ev_set; // RQ4
		else
			status_q <= status_q | ev_set; // RQ4
	end

	// level interrupt from pending and enabled conditions
	always_ff @(posedge clock)
	begin
		if (!rstn)
			host_irq_n <= 1'b1;
		else
			host_irq_n <= ~|(status_q & ctrl_q[vcd_pkg::CTL_IE +: 6]); // RQ21
	end

	// ------------------------------------------------------------
	// arbiter
	// ------------------------------------------------------------
	// hold grant while owner requests, then pass to highest requester
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			own_v_q <= 1'b0;
			owner_q <= vcd_pkg::ARB_NONE;
		end
		else if (own_v_q && !unit_req[owner_q])
			own_v_q <= 1'b0; // RQ20
		else if (!own_v_q && bus_gnt && (|unit_req))
		begin
			own_v_q <= 1'b1;
			if (unit_req[0])
				owner_q <= 2'h0; // RQ20
			else if (unit_req[1])
				owner_q <= 2'h1;
			else if (unit_req[2])
				owner_q <= 2'h2;
			else
				owner_q <= 2'h3;
		end
	end

	assign bus_req = (|unit_req) || own_v_q; // RQ20
	always_comb
	begin
		unit_gnt = '0;
		if (own_v_q && bus_gnt)
			unit_gnt[owner_q] = 1'b1;
	end

	// beat mux from the owning unit
	always_comb
	begin
		bus_valid = 1'b0;
		bus_write = 1'b0;
		bus_addr = '0;
		bus_wdata = '0;
		case (owner_q)
			2'h0:
			begin
				bus_valid = unit_gnt[0] && f_valid[0];
				bus_addr = f_addr[0];
			end
			2'h1:
			begin
				bus_valid = unit_gnt[1] && d_valid[0];
				bus_write = 1'b1;
				bus_addr = d_addr[0];
				bus_wdata = d_data[0];
			end
			2'h2:
			begin
				bus_valid = unit_gnt[2] && f_valid[1];
				bus_addr = f_addr[1];
			end
			2'h3:
			begin
				bus_valid = unit_gnt[3] && d_valid[1];
				bus_write = 1'b1;
				bus_addr = d_addr[1];
				bus_wdata = d_data[1];
			end
			default:
			begin
				bus_valid = 1'b0;
			end
		endcase
	end

	// register read, one cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (!rstn)
			reg_rdata <= '0;
		else if (!reg_rd)
			reg_rdata <= '0;
		else if (reg_addr == vcd_pkg::OFF_CTRL)
			reg_rdata <= ctrl_q;
		else if (reg_addr == vcd_pkg::OFF_STATUS)
			reg_rdata <= {26'h0, status_q};
		else if (reg_addr[7:6] == vcd_pkg::CH_SEL_A)
			reg_rdata <= ch_rdata[0];
		else if (reg_addr[7:6] == (vcd_pkg::CH_SEL_A + 2'h1))
			reg_rdata <= ch_rdata[1];
		else
			reg_rdata <= '0;
	end

	// ------------------------------------------------------------
	// channels
	// ------------------------------------------------------------
	for (genvar c = 0; c < vcd_pkg::NCH; c++)
	begin : g_ch
		logic [63:0] fifo_mem [vcd_pkg::FIFO_DEPTH];
		logic [7:0] wp_q, rp_q, cnt, thresh_q;
		logic [31:0] rowlen_q, rowcnt_q, fetch_q, first_q;
		logic [8:0] dwoff_q;
		logic [32:0] cache_q [vcd_pkg::CACHE_N];
		logic en, ilv, halt_q, act_q, eofp_q, drop_q, field2_q;
		logic f_busy_q, f_wait_q;
		logic [1:0] f_idx_q;
		logic sel, full, push, d_fire, f_fire, go, done;
		logic [9:0] dw_next;
		logic [5:0] off;

		assign en = ctrl_q[vcd_pkg::CTL_EN + c];
		assign ilv = ctrl_q[vcd_pkg::CTL_ILV + c];
		assign sel = reg_addr[7:6] == (vcd_pkg::CH_SEL_A + 2'(c));
		assign off = reg_addr[5:0];
		assign cnt = wp_q - rp_q;
		assign full = cnt[7];
		assign push = en && !halt_q && pix_valid[c] && !full;
		// descriptor at zero must be a plain page pointer for data beats
		assign go = en && !halt_q && !f_busy_q && cache_q[0][vcd_pkg::D_VALID] &&
			!cache_q[0][vcd_pkg::D_STOP] && !cache_q[0][vcd_pkg::D_JUMP];
		assign d_valid[c] = go && act_q && (cnt != 8'h00);
		assign d_fire = bus_valid && bus_ready && unit_gnt[2*c+1];
		assign d_addr[c] = {2'b00, cache_q[0][29:12], dwoff_q, 3'b000}; // RQ10 RQ17
		assign d_data[c] = ctrl_q[vcd_pkg::CTL_LITTLE] ? fifo_mem[rp_q[6:0]] :
			vcd_swap(fifo_mem[rp_q[6:0]]); // RQ1
		assign unit_req[2*c+1] = go && act_q; // RQ23 RQ25
		assign unit_req[2*c] = f_busy_q && !halt_q; // RQ25
		assign f_valid[c] = f_busy_q && !f_wait_q;
		assign f_addr[c] = fetch_q + {28'h0, f_idx_q, 2'b00};
		assign f_fire = bus_valid && bus_ready && unit_gnt[2*c];
		assign done = eofp_q && (cnt == 8'h00) && !d_fire; // RQ5
		localparam logic [9:0] DW2 = vcd_pkg::DW_STEP + vcd_pkg::DW_STEP;
		// a row end in interleave also skips one memory line
		assign dw_next = (ilv && (rowcnt_q == rowlen_q)) ?
			{1'b0, dwoff_q} + {1'b0, rowlen_q[11:3]} + DW2 :
			{1'b0, dwoff_q} + vcd_pkg::DW_STEP; // RQ24

		assign ev_set[vcd_pkg::NEV*c + vcd_pkg::EV_OVF] =
			en && !halt_q && pix_valid[c] && full; // RQ6
		assign ev_set[vcd_pkg::NEV*c + vcd_pkg::EV_EOT] = en && !halt_q &&
			!f_busy_q && cache_q[0][vcd_pkg::D_VALID] && cache_q[0][vcd_pkg::D_STOP]; // RQ7
		assign ev_set[vcd_pkg::NEV*c + vcd_pkg::EV_EOF] = done && en && !drop_q; // RQ22

		// fifo storage, and pointers cleared while disabled
		always_ff @(posedge clock)
		begin
			if (push)
				fifo_mem[wp_q[6:0]] <= pix_data[64*c +: 64]; // RQ19
		end

		always_ff @(posedge clock)
		begin
			if (!rstn || !en)
			begin
				wp_q <= '0; // RQ2
				rp_q <= '0; // RQ2
			end
			else
			begin
				if (push)
					wp_q <= wp_q + 8'h01;
				if (d_fire)
					rp_q <= rp_q + 8'h01;
			end
		end

		// transfer activity: start at threshold or field end, stop on empty
		always_ff @(posedge clock)
		begin
			if (!rstn || !en || halt_q)
				act_q <= 1'b0;
			else if ((cnt >= thresh_q || eofp_q) && cnt != 8'h00)
				act_q <= 1'b1; // RQ23
			else if (cnt == 8'h00)
				act_q <= 1'b0; // RQ23
		end

		// field end bookkeeping
		always_ff @(posedge clock)
		begin
			if (!rstn || !en)
			begin
				eofp_q <= 1'b0;
				drop_q <= 1'b0;
			end
			else if (field_end[c])
			begin
				eofp_q <= 1'b1;
				drop_q <= field_drop[c];
			end
			else if (done)
				eofp_q <= 1'b0;
		end

		// halt after stop or overflow until flag cleared and pointer rewritten
		always_ff @(posedge clock)
		begin
			if (!rstn)
				halt_q <= 1'b0;
			else if (ev_set[vcd_pkg::NEV*c + vcd_pkg::EV_OVF] ||
				ev_set[vcd_pkg::NEV*c + vcd_pkg::EV_EOT])
				halt_q <= 1'b1; // RQ6 RQ7
			else if (reg_wr && sel && off == vcd_pkg::OFF_FETCH &&
				!status_q[vcd_pkg::NEV*c + vcd_pkg::EV_OVF] &&
				!status_q[vcd_pkg::NEV*c + vcd_pkg::EV_EOT])
				halt_q <= 1'b0; // RQ25
		end

		// descriptor cache, offsets, row counter and fetch unit
		always_ff @(posedge clock)
		begin
			if (!rstn)
			begin
				for (int i = 0; i < vcd_pkg::CACHE_N; i++)
					cache_q[i] <= '0;
				rowlen_q <= '0;
				rowcnt_q <= '0;
				dwoff_q <= '0;
				fetch_q <= '0;
				first_q <= '0;
				thresh_q <= vcd_pkg::THRESH_RST;
				f_busy_q <= 1'b0;
				f_wait_q <= 1'b0;
				f_idx_q <= '0;
				field2_q <= 1'b0;
			end
			else
			begin
				if (d_fire)
				begin
					rowcnt_q <= (rowcnt_q == rowlen_q) ? '0 : rowcnt_q + vcd_pkg::ROW_STEP; // RQ9
					dwoff_q <= dw_next[8:0];
					if (dw_next[9])
					begin
						for (int i = 0; i < vcd_pkg::CACHE_N - 1; i++)
							cache_q[i] <= cache_q[i+1]; // RQ14
						cache_q[vcd_pkg::CACHE_N-1] <= '0; // RQ14
					end
				end
				if (done && ilv && !field2_q)
				begin
					// first field done: rewind to frame top, odd lines
					field2_q <= 1'b1; // RQ3
					fetch_q <= first_q; // RQ3
					for (int i = 0; i < vcd_pkg::CACHE_N; i++)
						cache_q[i] <= '0;
					dwoff_q <= rowlen_q[11:3] + 9'h001; // RQ3
					rowcnt_q <= '0;
				end
				else if (done && ilv)
				begin
					// frame done: next frame starts at current fetch pointer
					field2_q <= 1'b0; // RQ3
					first_q <= fetch_q; // RQ3
					for (int i = 0; i < vcd_pkg::CACHE_N; i++)
						cache_q[i] <= '0;
					dwoff_q <= '0;
					rowcnt_q <= '0;
				end
				else if (done)
				begin
					// next field on a fresh page
					for (int i = 0; i < vcd_pkg::CACHE_N - 1; i++)
						cache_q[i] <= cache_q[i+1];
					cache_q[vcd_pkg::CACHE_N-1] <= '0;
					dwoff_q <= '0;
				end
				// fetch unit: four reads, one outstanding at a time
				if (f_fire)
					f_wait_q <= 1'b1;
				if (f_busy_q && bus_rvalid && unit_gnt[2*c])
				begin
					cache_q[f_idx_q] <= {1'b1, bus_rdata};
					f_wait_q <= 1'b0;
					f_idx_q <= f_idx_q + 2'h1;
					if (f_idx_q == 2'h3)
					begin
						f_busy_q <= 1'b0;
						fetch_q <= fetch_q + vcd_pkg::FETCH_STEP; // RQ11
					end
				end
				else if (!f_busy_q && !halt_q && !d_fire && !done &&
					!cache_q[0][vcd_pkg::D_VALID] && fetch_q != 32'h0)
				begin
					f_busy_q <= 1'b1; // RQ14
					f_idx_q <= '0;
				end
				else if (!f_busy_q && !halt_q && !done && cache_q[0][vcd_pkg::D_VALID] &&
					cache_q[0][vcd_pkg::D_JUMP] && !cache_q[0][vcd_pkg::D_STOP])
				begin
					fetch_q <= {2'b00, cache_q[0][29:0]}; // RQ15 RQ17
					for (int i = 0; i < vcd_pkg::CACHE_N; i++)
						cache_q[i] <= '0; // RQ15
				end
				// software writes win over the engine
				if (reg_wr && sel)
				begin
					case (off)
						vcd_pkg::OFF_ROWLEN: rowlen_q <= reg_wdata;
						vcd_pkg::OFF_ROWCNT: rowcnt_q <= reg_wdata;
						vcd_pkg::OFF_DWOFF: dwoff_q <= reg_wdata[11:3];
						vcd_pkg::OFF_FIRST: first_q <= reg_wdata;
						vcd_pkg::OFF_THRESH: thresh_q <= reg_wdata[7:0];
						vcd_pkg::OFF_FETCH:
						begin
							fetch_q <= reg_wdata;
							for (int i = 0; i < vcd_pkg::CACHE_N; i++)
								cache_q[i] <= '0; // RQ16
							f_busy_q <= 1'b1; // RQ16
							f_wait_q <= 1'b0;
							f_idx_q <= '0;
							field2_q <= 1'b0;
						end
						default:
						begin
							if (off[5:4] == vcd_pkg::OFF_CACHE_HI[1:0])
								cache_q[off[3:2]] <= {1'b1, reg_wdata}; // RQ13
						end
					endcase
				end
			end
		end

		// channel register read data
		always_comb
		begin
			case (off)
				vcd_pkg::OFF_ROWLEN: ch_rdata[c] = rowlen_q;
				vcd_pkg::OFF_ROWCNT: ch_rdata[c] = rowcnt_q;
				vcd_pkg::OFF_DWOFF: ch_rdata[c] = {20'h0, dwoff_q, 3'b000};
				vcd_pkg::OFF_FETCH: ch_rdata[c] = fetch_q;
				vcd_pkg::OFF_FIRST: ch_rdata[c] = first_q;
				vcd_pkg::OFF_THRESH: ch_rdata[c] = {24'h0, thresh_q};
				vcd_pkg::OFF_FIFOPTR: ch_rdata[c] = {16'h0, wp_q, rp_q}; // RQ19
				vcd_pkg::OFF_CVALID: ch_rdata[c] = {28'h0, cache_q[3][32],
					cache_q[2][32], cache_q[1][32], cache_q[0][32]}; // RQ13
				default:
				begin
					if (off[5:4] == vcd_pkg::OFF_CACHE_HI[1:0])
						ch_rdata[c] = cache_q[off[3:2]][31:0];
					else
						ch_rdata[c] = '0;
				end
			endcase
		end
	end
endmodule : vcd_dma
`default_nettype wire

// ==== testbench/vcd_bus_model.sv ====
// system bus partner: arbiter grant, slow acceptance and descriptor memory
`timescale 1ns/1ps
`default_nettype none
module vcd_bus_model (
	input wire logic clock, // clock
	input wire logic rstn, // reset, active low
	input wire logic bus_req, // request from the engine
	input wire logic bus_valid, // beat offered
	input wire logic bus_write, // write beat
	input wire logic [31:0] bus_addr, // beat address
	output logic bus_gnt, // grant
	output logic bus_ready, // beat taken
	output logic bus_rvalid, // read word back
	output logic [31:0] bus_rdata // read word
);
	// ------------------------------------------------------------
	// memory and handshake
	// ------------------------------------------------------------
	logic stall_q;
	logic take;
	// every table holds three pages and ends with a stop word
	function automatic logic [31:0] desc(input logic [31:0] a);
		if (a[3:2] == 2'h3)
			return 32'h8000_0000;
		return 32'h0010_0000 | {18'h0, a[3:2], 12'h000};
	endfunction : desc
	assign bus_ready = bus_valid && bus_gnt && !stall_q;
	assign take = bus_ready && !bus_write;
	// grant follows request; idle read data toggles so stale words never match
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			bus_gnt <= 1'b0;
			stall_q <= 1'b0;
			bus_rvalid <= 1'b0;
			bus_rdata <= 32'h0;
		end
		else
		begin
			bus_gnt <= bus_req;
			stall_q <= ($urandom_range(0, 3) == 0);
			bus_rvalid <= take;
			bus_rdata <= take ? desc(bus_addr) : ~bus_rdata;
		end
	end
endmodule : vcd_bus_model
`default_nettype wire

// ==== testbench/vcd_dma_asserts.sv ====
// concurrent checks on the capture dma ports
`timescale 1ns/1ps
`default_nettype none
module vcd_dma_asserts (
	input wire logic clock, // clock
	input wire logic rstn, // reset, active low
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [31:0] reg_rdata, // read data
	input wire logic bus_req, // bus request
	input wire logic bus_gnt, // bus grant
	input wire logic bus_valid, // beat offered
	input wire logic bus_write, // write beat
	input wire logic [31:0] bus_addr, // beat address
	input wire logic [63:0] bus_wdata, // beat data
	input wire logic bus_ready, // beat taken
	input wire logic bus_rvalid, // read word back
	input wire logic host_irq_n // interrupt, active low
);
	// ------------------------------------------------------------
	// helpers and properties
	// ------------------------------------------------------------
	logic rd_wait_q;
	logic [31:0] last_rd_q;
	logic rd_take;
	assign rd_take = bus_valid && bus_ready && !bus_write;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// last fetch address and whether its word is still outstanding
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			rd_wait_q <= 1'b0;
			last_rd_q <= 32'h0;
		end
		else
		begin
			rd_wait_q <= rd_take || (rd_wait_q && !bus_rvalid);
			if (rd_take)
				last_rd_q <= bus_addr;
		end
	end
	property p_beat_gnt;
		bus_valid |-> bus_gnt && bus_req;
	endproperty
	a_beat_gnt: assert property (p_beat_gnt) else $error("beat without grant");
	property p_release;
		$fell(bus_req) |-> $past(!bus_valid || bus_ready);
	endproperty
	a_release: assert property (p_release) else $error("bus dropped mid beat");
	property p_align;
		bus_valid |-> bus_addr[31:30] == 2'h0 && bus_addr[1:0] == 2'h0 &&
			(!bus_write || !bus_addr[2]);
	endproperty
	a_align: assert property (p_align) else $error("bad beat address bits");
	property p_hold;
		bus_valid && !bus_ready |=> bus_valid && $stable(bus_addr) && $stable(bus_write)
			&& $stable(bus_wdata);
	endproperty
	a_hold: assert property (p_hold) else $error("beat changed while waiting");
	property p_fetch_step;
		rd_take && bus_addr[3:2] != 2'h0 |-> bus_addr == last_rd_q + 32'h4;
	endproperty
	a_fetch_step: assert property (p_fetch_step) else $error("fetch address step");
	property p_rd_wait;
		rd_wait_q && !bus_rvalid |-> !(bus_valid && !bus_write);
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read before word back");
	property p_irq_clear;
		$rose(host_irq_n) |-> $past(reg_wr, 2);
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq cleared by itself");
	property p_rdata_zero;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside slot");
endmodule : vcd_dma_asserts
bind vcd_dma vcd_dma_asserts u_chk (.clock(clock), .rstn(rstn), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req), .bus_gnt(bus_gnt),
	.bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_ready(bus_ready), .bus_rvalid(bus_rvalid),
	.host_irq_n(host_irq_n));
`default_nettype wire

// ==== testbench/test_vcd_dma.sv ====
// self-checking bench for the capture dma engine
`timescale 1ns/1ps
`default_nettype none
module test_vcd_dma;
	// ------------------------------------------------------------
	// stimulus, watchers and scenarios
	// ------------------------------------------------------------
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [1:0] pix_valid = 2'h0;
	logic [127:0] pix_data = 128'h0;
	logic [1:0] field_end = 2'h0;
	logic [1:0] field_drop = 2'h0;
	logic bus_req, bus_gnt, bus_valid, bus_write, bus_ready, bus_rvalid, host_irq_n;
	logic [31:0] bus_addr, bus_rdata;
	logic [63:0] bus_wdata;
	logic rd_seen = 1'b0;
	logic [31:0] rq[$];
	logic [31:0] aq[$];
	logic [63:0] dq[$];
	int bad_count = 0;
	int check_count = 0;
	int k;
	always #2.5 clock = ~clock;
	vcd_dma uut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
		.pix_data(pix_data), .field_end(field_end), .field_drop(field_drop),
		.bus_req(bus_req), .bus_gnt(bus_gnt), .bus_valid(bus_valid), .bus_write(bus_write),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ready(bus_ready),
		.bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata), .host_irq_n(host_irq_n));
	vcd_bus_model u_bus (.clock(clock), .rstn(rstn), .bus_req(bus_req), .bus_valid(bus_valid),
		.bus_write(bus_write), .bus_addr(bus_addr), .bus_gnt(bus_gnt), .bus_ready(bus_ready),
		.bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// read data and write beats are matched against the oldest note
	always @(posedge clock)
	begin
		if (rd_seen)
			chk(64'(reg_rdata), 64'(rq.pop_front()));
		rd_seen <= reg_rd;
		if (bus_valid === 1'b1 && bus_ready === 1'b1 && bus_write === 1'b1)
		begin
			chk(64'(bus_addr), 64'(aq.pop_front()));
			chk(bus_wdata, dq.pop_front());
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask : rd
	// base zero means no beat may follow
	task automatic push(input int ch, input int n, input logic big, input logic [31:0] base);
		logic [63:0] w;
		logic [63:0] s;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clock);
			w = {$urandom, $urandom};
			s = {<<8{w}};
			pix_data <= (ch == 1) ? {w, 64'h0} : {64'h0, w};
			pix_valid <= (ch == 1) ? 2'h2 : 2'h1;
			if (base != 32'h0)
			begin
				aq.push_back(base + 32'(8 * i));
				dq.push_back(big ? s : w);
			end
		end
		@(posedge clock);
		pix_valid <= 2'h0;
	endtask : push
	task automatic pulse(input logic [1:0] fe, input logic [1:0] drop);
		@(posedge clock);
		field_end <= fe;
		field_drop <= drop;
		@(posedge clock);
		field_end <= 2'h0;
		field_drop <= 2'h0;
	endtask : pulse
	task automatic wait_idle;
		int i;
		repeat (4) @(posedge clock);
		for (i = 0; i < 500; i++)
		begin
			@(posedge clock);
			if (bus_req === 1'b0 && aq.size() == 0)
				break;
		end
		if (i == 500)
		begin
			bad_count++;
			give_verdict();
		end
		repeat (8) @(posedge clock);
	endtask : wait_idle
	// scenarios in order; each leaves state for the next
	initial
	begin
		void'($urandom(24764));
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		rd(8'h04, 32'h0);
		rd(8'h54, 32'h40);
		rd(8'h58, 32'h0);
		rd(8'hfc, 32'h0);
		wr(8'h64, 32'h1234_5678);
		rd(8'h5c, 32'h2);
		rd(8'h64, 32'h1234_5678);
		$display("test reset and cache done");
		wr(8'h48, 32'h0);
		wr(8'h50, 32'h1000);
		wr(8'h4c, 32'h1000);
		wait_idle();
		rd(8'h5c, 32'hf);
		for (k = 0; k < 3; k++)
			rd(8'h60 + 8'(4 * k), 32'h0010_0000 | (32'(k) << 12));
		rd(8'h6c, 32'h8000_0000);
		rd(8'h4c, 32'h1010);
		$display("test fetch done");
		wr(8'h40, 32'h20);
		wr(8'h54, 32'h2);
		wr(8'h00, 32'ha3);
		push(0, 3, 1'b0, 32'h0010_0000);
		wait_idle();
		rd(8'h44, 32'h18);
		rd(8'h58, 32'h0303);
		rd(8'h48, 32'h18);
		pulse(2'h1, 2'h0);
		wait_idle();
		rd(8'h04, 32'h4);
		chk(64'(host_irq_n), 64'h0);
		wr(8'h04, 32'h4);
		repeat (3) @(posedge clock);
		chk(64'(host_irq_n), 64'h1);
		rd(8'h04, 32'h0);
		$display("test dma and field end done");
		wr(8'h00, 32'ha2);
		push(0, 2, 1'b1, 32'h0010_1000);
		wait_idle();
		pulse(2'h1, 2'h1);
		wait_idle();
		rd(8'h04, 32'h0);
		$display("test byte order and dropped field done");
		wr(8'h00, 32'h0);
		rd(8'h58, 32'h0);
		wr(8'h60, 32'h8000_0000);
		wr(8'h00, 32'ha3);
		repeat (4) @(posedge clock);
		rd(8'h04, 32'h1);
		chk(64'(host_irq_n), 64'h0);
		push(0, 3, 1'b0, 32'h0);
		repeat (20) @(posedge clock);
		chk(64'(bus_req), 64'h0);
		$display("test stop descriptor done");
		wr(8'ha0, 32'h4000_2000);
		wr(8'h90, 32'h2000);
		wr(8'h80, 32'h8);
		wr(8'h94, 32'h2);
		wait_idle();
		rd(8'h8c, 32'h2010);
		wr(8'h00, 32'h15);
		for (k = 0; k < 2; k++)
			push(1, 2, 1'b0, 32'h0010_0000 | (32'(k) << 5));
		pulse(2'h2, 2'h0);
		wait_idle();
		for (k = 0; k < 2; k++)
			push(1, 2, 1'b0, 32'h0010_0010 | (32'(k) << 5));
		pulse(2'h2, 2'h0);
		wait_idle();
		rd(8'h90, 32'h2010);
		rd(8'h04, 32'h21);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h20);
		$display("test jump and interleave done");
		wr(8'h94, 32'hff);
		wr(8'h00, 32'h204);
		push(1, 128, 1'b0, 32'h0);
		rd(8'h98, 32'h8000);
		rd(8'h04, 32'h1);
		chk(64'(host_irq_n), 64'h1);
		push(1, 1, 1'b0, 32'h0);
		rd(8'h04, 32'h11);
		chk(64'(host_irq_n), 64'h0);
		wr(8'h00, 32'h0);
		rd(8'h98, 32'h0);
		repeat (2) @(posedge clock);
		$display("test overflow done");
		give_verdict();
	end
endmodule : test_vcd_dma
`default_nettype wire
